// File: sff_pkg.sv
// Shared constants and state types for the SPI fault-flag and select-mode block
package sff_pkg;
    // Register addresses on the special-function register port
    localparam logic [7:0] SFF_CTRL_ADDR = 8'hF8;
    localparam logic [7:0] SFF_DATA_ADDR = 8'hF9;
    // Control/status field positions
    localparam int SFF_WRITE_COLLISION_FLAG_BIT = 6;
    localparam int SFF_MODF_BIT = 5;
    localparam int SFF_RXOVR_BIT = 4;
    localparam int SFF_MODE_HI = 3;
    localparam int SFF_MODE_LO = 2;
    // Select-mode encodings and reset value
    localparam logic [1:0] SFF_MODE_MULTI_IN = 2'h1;
    localparam logic [1:0] SFF_MODE_RESET = 2'h1;
    localparam logic [7:0] SFF_BYTE_RESET = 8'h00;
    // Transfer shape and receive buffering
    localparam int SFF_XFER_BITS = 8;
    localparam int SFF_FIFO_DEPTH = 32;
    localparam logic [2:0] SFF_LAST_BIT = 3'h7;

    // One register-port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sff_sfr_req_t;

    // State on the system clock
    typedef struct packed {
        logic write_collision_flag;
        logic modf;
        logic rxovr;
        logic [1:0] select_pin_mode_field;
        logic busy;
        logic start_tgl;
        logic [7:0] tx_byte;
        logic done_s1;
        logic done_s2;
        logic done_seen;
        logic nss_s1;
        logic nss_s2;
        logic [7:0] rdata;
        logic irq;
        logic ss_out;
        logic ss_oe;
    } sff_sys_t;

    // State on the link clock
    typedef struct packed {
        logic start_s1;
        logic start_s2;
        logic start_seen;
        logic active;
        logic [2:0] cnt;
        logic [7:0] shreg;
        logic [7:0] rx_byte;
        logic done_tgl;
        logic mosi;
    } sff_link_t;
endpackage : sff_pkg

// File: sff_fifo.sv
// Receive FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sff_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } sff_fifo_st_t;

    sff_fifo_st_t s;
    sff_fifo_st_t next_s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // Honest flags straight from the occupancy count
    assign o_in_ready = (s.count != (AW+1)'(DEPTH));
    assign o_out_valid = (s.count != '0);
    assign o_out_data = mem[s.rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = i_out_ready && o_out_valid;

    // Pointer and count update, wrap for non power-of-two depth
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wr_ptr = (s.wr_ptr == AW'(DEPTH - 1)) ? '0 : s.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_s.rd_ptr = (s.rd_ptr == AW'(DEPTH - 1)) ? '0 : s.rd_ptr + 1'b1;
        end
        next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Storage needs no reset; only written entries are ever read
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[s.wr_ptr] <= i_in_data;
        end
    end
endmodule : sff_fifo
`default_nettype wire

// File: sff_spi_flags.sv
// SPI port with sticky fault flags, select-pin modes and a link-clock shifter
// Summary of operation
// [R1] Data write during a transfer sets write-collision flag and raises interrupt.
// [R2] Software clears write-collision by writing zero; hardware never clears it.
// [R3] Select low, master enabled, mode 01 sets mode-fault flag and interrupt.
// [R4] Mode-fault flag stays set until software clears it.
// [R5] Last bit arriving while receive buffer holds unread data sets overrun; here only when the receive FIFO is full.
// [R6] Overrun flag stays set until software clears it.
// [R7] Control bits 3:2 hold the select-pin mode field.
// [R8] Mode 01, the reset default, keeps the select pin an input.
// [R9] Mode 1x drives the select pin with the field's low bit.
`timescale 1ns/1ns
`default_nettype none
module sff_spi_flags
    import sff_pkg::*;
#(
    parameter int FIFO_DEPTH = SFF_FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_link_clk,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    input wire logic i_master_operation_enable,
    input wire logic i_slave_select_pin_n,
    output logic o_slave_select_pin_n,
    output logic o_slave_select_pin_oe,
    input wire logic i_miso,
    output logic o_mosi,
    output logic o_port_irq
);
    sff_sys_t s;
    sff_sys_t next_s;
    sff_link_t l;
    sff_link_t next_l;
    sff_sfr_req_t req;
    logic wr_ctrl;
    logic wr_data;
    logic rd_ctrl;
    logic rd_data;
    logic done_evt;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_push;
    logic fifo_pop;

    // Bundle the register port and decode it
    assign req = '{wr: i_sfr_wr, rd: i_sfr_rd, addr: i_sfr_addr, wdata: i_sfr_wdata};
    assign wr_ctrl = req.wr && (req.addr == SFF_CTRL_ADDR);
    assign wr_data = req.wr && (req.addr == SFF_DATA_ADDR);
    assign rd_ctrl = req.rd && (req.addr == SFF_CTRL_ADDR);
    assign rd_data = req.rd && (req.addr == SFF_DATA_ADDR);

    // Completion toggle seen after two stages; edge found on the second
    assign done_evt = s.done_s2 ^ s.done_seen;
    // Completed byte enters the buffer only if there is room
    assign fifo_push = done_evt && fifo_in_ready;
    assign fifo_pop = rd_data;

    // Received bytes; the byte word is stable once the toggle is seen
    sff_fifo #(
        .WIDTH(SFF_XFER_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(fifo_push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(l.rx_byte),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_out_data)
    );

    // System-clock next state
    always_comb begin
        next_s = s;
        // Two-stage capture of the select pin and the completion toggle
        next_s.nss_s1 = i_slave_select_pin_n;
        next_s.nss_s2 = s.nss_s1;
        next_s.done_s1 = l.done_tgl;
        next_s.done_s2 = s.done_s1;
        next_s.done_seen = s.done_s2;

        // Start a transfer; tx byte held steady while busy for the crossing
        if (wr_data && !s.busy) begin
            next_s.tx_byte = req.wdata;
            next_s.start_tgl = ~s.start_tgl;
            next_s.busy = 1'b1;
        end
        if (done_evt) begin
            next_s.busy = 1'b0;
        end

        // Select mode field is plain read/write
        if (wr_ctrl) begin
            next_s.select_pin_mode_field = req.wdata[SFF_MODE_HI:SFF_MODE_LO]; // [R7]
        end

        // Sticky flags: writing zero clears, writing one is ignored, set wins
        next_s.write_collision_flag = (s.write_collision_flag
            & ~(wr_ctrl & ~req.wdata[SFF_WRITE_COLLISION_FLAG_BIT]))                 // [R2]
            | (wr_data & s.busy);                                      // [R1]
        next_s.modf = (s.modf & ~(wr_ctrl & ~req.wdata[SFF_MODF_BIT])) // [R4]
            | (!s.nss_s2 && i_master_operation_enable
               && (s.select_pin_mode_field == SFF_MODE_MULTI_IN));     // [R3]
        next_s.rxovr = (s.rxovr & ~(wr_ctrl & ~req.wdata[SFF_RXOVR_BIT])) // [R6]
            | (done_evt & ~fifo_in_ready);                             // [R5]

        // Port interrupt follows any pending flag
        next_s.irq = next_s.write_collision_flag | next_s.modf | next_s.rxovr; // [R1]

        // Select pin: input in modes 0x, driven with the low bit in 1x
        next_s.ss_oe = next_s.select_pin_mode_field[1];   // [R8]
        next_s.ss_out = next_s.select_pin_mode_field[0];  // [R9]

        // Read data registered one cycle after the strobe
        if (rd_ctrl) begin
            next_s.rdata = 8'h00;
            next_s.rdata[SFF_WRITE_COLLISION_FLAG_BIT] = s.write_collision_flag;
            next_s.rdata[SFF_MODF_BIT] = s.modf;
            next_s.rdata[SFF_RXOVR_BIT] = s.rxovr;
            next_s.rdata[SFF_MODE_HI:SFF_MODE_LO] = s.select_pin_mode_field;
        end else if (rd_data) begin
            next_s.rdata = fifo_out_valid ? fifo_out_data : 8'h00;
        end
    end

    // Mode reset value makes the select pin an input out of reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
            s.select_pin_mode_field <= SFF_MODE_RESET; // [R8]
            s.nss_s1 <= 1'b1;
            s.nss_s2 <= 1'b1;
            s.ss_out <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Link-clock shifter: start toggle caught in two stages, MSB first
    always_comb begin
        next_l = l;
        next_l.start_s1 = s.start_tgl;
        next_l.start_s2 = l.start_s1;
        next_l.start_seen = l.start_s2;
        if (l.active) begin
            next_l.mosi = l.shreg[7];
            next_l.shreg = {l.shreg[6:0], i_miso};
            next_l.cnt = l.cnt + 3'h1;
            if (l.cnt == SFF_LAST_BIT) begin
                // Last bit in: publish the byte and flip the toggle on the same edge
                next_l.rx_byte = {l.shreg[6:0], i_miso}; // [R5]
                next_l.done_tgl = ~l.done_tgl;
                next_l.active = 1'b0;
            end
        end else if (l.start_s2 ^ l.start_seen) begin
            // Tx byte is stable here since the system side holds it while busy
            next_l.shreg = s.tx_byte;
            next_l.cnt = 3'h0;
            next_l.active = 1'b1;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            l <= '0;
            l.rx_byte <= SFF_BYTE_RESET;
        end else begin
            l <= next_l;
        end
    end

    // Outputs straight from flops
    assign o_sfr_rdata = s.rdata;
    assign o_port_irq = s.irq;
    assign o_slave_select_pin_n = s.ss_out;
    assign o_slave_select_pin_oe = s.ss_oe;
    assign o_mosi = l.mosi;
endmodule : sff_spi_flags
`default_nettype wire

// File: sff_spi_flags_props.sv
// Port checker for the SPI fault-flag and select-mode block
`timescale 1ns/1ns
`default_nettype none
module sff_spi_flags_props
    import sff_pkg::*;
#(
    parameter int FIFO_DEPTH = SFF_FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic i_master_operation_enable,
    input wire logic i_slave_select_pin_n,
    input wire logic o_slave_select_pin_n,
    input wire logic o_slave_select_pin_oe,
    input wire logic o_port_irq
);
    logic [1:0] mode_q;
    logic ctrl_wr, ctrl_rd, data_wr, fault_in;
    // Decoded strobes
    assign ctrl_wr = i_sfr_wr && (i_sfr_addr == SFF_CTRL_ADDR);
    assign ctrl_rd = i_sfr_rd && (i_sfr_addr == SFF_CTRL_ADDR);
    assign data_wr = i_sfr_wr && (i_sfr_addr == SFF_DATA_ADDR);
    assign fault_in = !i_slave_select_pin_n && i_master_operation_enable;
    // Shadow of the mode field, so pin checks need no internal probes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_q <= SFF_MODE_RESET;
        end else if (ctrl_wr) begin
            mode_q <= i_sfr_wdata[SFF_MODE_HI:SFF_MODE_LO];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_mode_output: assert property ($past(mode_q) == mode_q && mode_q[1]
        |-> o_slave_select_pin_oe && o_slave_select_pin_n == mode_q[0])
        else $error("select pin not driven with low mode bit");
    a_mode_input: assert property ($past(mode_q) == mode_q && !mode_q[1]
        |-> !o_slave_select_pin_oe) else $error("select pin driven in input mode");
    a_pin_only_write: assert property (!$past(ctrl_wr) && !$past(ctrl_wr, 2)
        |-> $stable({o_slave_select_pin_oe, o_slave_select_pin_n}))
        else $error("select pin changed without a control write");
    a_readback_mode: assert property (ctrl_rd |=> o_sfr_rdata[3:2] == $past(mode_q)
        && o_sfr_rdata[7] == 1'b0 && o_sfr_rdata[1:0] == 2'h0)
        else $error("control readback wrong");
    a_irq_matches: assert property (ctrl_rd |=> (|o_sfr_rdata[6:4]) == o_port_irq)
        else $error("interrupt disagrees with flags");
    a_irq_sticky: assert property (o_port_irq && !ctrl_wr && !$past(ctrl_wr)
        |=> o_port_irq) else $error("interrupt dropped without a clear");
    a_fault_detect: assert property ((fault_in && mode_q == SFF_MODE_MULTI_IN)[*4]
        |-> ##[0:2] o_port_irq) else $error("mode fault not flagged");
    a_collision_irq: assert property (data_wr ##1 data_wr |-> ##[1:3] o_port_irq)
        else $error("write collision not flagged");
    a_rdata_hold: assert property (!$past(i_sfr_rd) |-> $stable(o_sfr_rdata))
        else $error("read data changed without a read");
    c_fault: cover property (fault_in ##4 o_port_irq);
    c_drive: cover property (o_slave_select_pin_oe && !o_slave_select_pin_n);
    c_overrun: cover property (ctrl_rd ##1 o_sfr_rdata[SFF_RXOVR_BIT]);
endmodule : sff_spi_flags_props
bind sff_spi_flags sff_spi_flags_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.i_clk, .i_rst_n,
    .i_sfr_wr, .i_sfr_rd, .i_sfr_addr, .i_sfr_wdata, .o_sfr_rdata, .i_master_operation_enable,
    .i_slave_select_pin_n, .o_slave_select_pin_n, .o_slave_select_pin_oe, .o_port_irq);
`default_nettype wire

// File: sff_link_partner.sv
// Far-end link device that echoes the inverse of each bit it receives
`timescale 1ns/1ns
`default_nettype none
module sff_link_partner (
    input wire logic i_link_clk,
    input wire logic i_rst_n,
    input wire logic i_mosi,
    output logic o_miso
);
    // Inverted echo keeps the line toggling, so a stale level never passes
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_miso <= 1'b1;
        end else begin
            o_miso <= ~i_mosi;
        end
    end
endmodule : sff_link_partner
`default_nettype wire

// File: sff_spi_flags_tb.sv
// Self-checking bench for the SPI fault-flag and select-mode block
`timescale 1ns/1ns
`default_nettype none
module sff_spi_flags_tb;
    import sff_pkg::*;
    logic clk = 0, lclk = 0, rst_n = 0, wr = 0, rd = 0, men = 0, ext_ss_n = 1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
    logic ss_n, sel_n, sel_oe, mosi, miso, irq;
    int errors = 0, check_count = 0, cycles = 0;
    // Select wire: the block wins while it drives, else the outside level
    assign ss_n = sel_oe ? sel_n : ext_ss_n;
    sff_spi_flags #(.FIFO_DEPTH(SFF_FIFO_DEPTH)) DUT (.i_clk(clk), .i_rst_n(rst_n),
        .i_link_clk(lclk), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_addr(addr),
        .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_master_operation_enable(men),
        .i_slave_select_pin_n(ss_n), .o_slave_select_pin_n(sel_n),
        .o_slave_select_pin_oe(sel_oe), .i_miso(miso), .o_mosi(mosi), .o_port_irq(irq));
    sff_link_partner u_far (.i_link_clk(lclk), .i_rst_n(rst_n), .i_mosi(mosi), .o_miso(miso));
    // Clocks; 7+8 ns keeps the 15 ns link clock on the 1 ns grid
    always #4 clk = ~clk;
    always begin
        #7 lclk = 1;
        #8 lclk = 0;
    end
    // Hang guard, far above the ~2300 cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors = errors + 1;
            finish_test();
        end
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : sfr_wr
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : sfr_rd
    task automatic t_modes();
        sfr_rd(SFF_CTRL_ADDR, d);
        check("ctrl reset", d, 8'h04);
        for (int m = 0; m < 4; m++) begin
            sfr_wr(SFF_CTRL_ADDR, 8'(m << 2));
            repeat (2) @(posedge clk);
            sfr_rd(SFF_CTRL_ADDR, d);
            check("mode field", d, 8'(m << 2));
            check("select pin", {6'h00, sel_oe, ss_n}, {6'h00, m[1], m[1] ? m[0] : 1'b1});
        end
        sfr_wr(SFF_CTRL_ADDR, 8'h04);
        $display("mode test done");
    endtask : t_modes
    task automatic t_fault();
        @(posedge clk);
        men <= 1'b1;
        ext_ss_n <= 1'b0;
        repeat (6) @(posedge clk);
        ext_ss_n <= 1'b1;
        sfr_rd(SFF_CTRL_ADDR, d);
        check("fault set", d, 8'h24);
        check("fault irq", {7'h00, irq}, 8'h01);
        sfr_wr(SFF_CTRL_ADDR, 8'h74);
        sfr_rd(SFF_CTRL_ADDR, d);
        check("fault held", d, 8'h24);
        sfr_wr(SFF_CTRL_ADDR, 8'h04);
        men <= 1'b0;
        sfr_rd(SFF_CTRL_ADDR, d);
        check("fault cleared", {d[7:1], irq}, 8'h04);
        $display("fault test done");
    endtask : t_fault
    task automatic t_collision();
        // Two data writes on back-to-back edges; the second lands while busy
        @(posedge clk);
        wr <= 1'b1;
        addr <= SFF_DATA_ADDR;
        wdata <= 8'hA5;
        @(posedge clk);
        wdata <= 8'h3C;
        @(posedge clk);
        wr <= 1'b0;
        sfr_rd(SFF_CTRL_ADDR, d);
        check("collision", d, 8'h44);
        repeat (60) @(posedge clk);
        sfr_rd(SFF_CTRL_ADDR, d);
        check("collision held", d, 8'h44);
        sfr_wr(SFF_CTRL_ADDR, 8'h04);
        sfr_rd(SFF_DATA_ADDR, d);
        // Echo lags two link edges: two idle ones, then inverted bits 7..2
        check("rx byte", d, 8'hD6);
        sfr_rd(SFF_CTRL_ADDR, d);
        check("collision cleared", d, 8'h04);
        $display("collision test done");
    endtask : t_collision
    task automatic t_overrun();
        // One byte past a full buffer; the wait covers a transfer
        for (int i = 0; i <= SFF_FIFO_DEPTH; i++) begin
            sfr_rd(SFF_CTRL_ADDR, d);
            check("no overrun", d, 8'h04);
            sfr_wr(SFF_DATA_ADDR, 8'(i));
            repeat (60) @(posedge clk);
        end
        sfr_rd(SFF_CTRL_ADDR, d);
        check("overrun", d, 8'h14);
        for (int i = 0; i < SFF_FIFO_DEPTH; i++) begin
            sfr_rd(SFF_DATA_ADDR, d);
        end
        sfr_rd(SFF_DATA_ADDR, d);
        check("empty read", d, 8'h00);
        sfr_rd(SFF_CTRL_ADDR, d);
        check("overrun held", d, 8'h14);
        sfr_wr(SFF_CTRL_ADDR, 8'h04);
        sfr_rd(SFF_CTRL_ADDR, d);
        check("overrun cleared", {d[7:1], irq}, 8'h04);
        $display("overrun test done");
    endtask : t_overrun
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_modes();
        t_fault();
        t_collision();
        t_overrun();
        finish_test();
    end
endmodule : sff_spi_flags_tb
`default_nettype wire
